// *** src/dbg_unit_pkg.sv ***
// constants, types and register map of the hardware breakpoint debug unit
package dbg_unit_pkg;

	// ************************************************************
	// sizes
	// ************************************************************
	localparam int ADDR_W      = 10;
	localparam int DATA_W      = 32;
	localparam int THREAD_IX_W = 3;
	localparam int NUM_THREADS = 8;
	localparam int NUM_UNITS   = 4;
	localparam int NUM_SCRATCH = 8;

	// ************************************************************
	// register indices; byte address is four times the index
	// ************************************************************
	localparam logic [7:0] IDX_SAVED_SP   = 8'h12;
	localparam logic [7:0] IDX_READ_THR   = 8'h13;
	localparam logic [7:0] IDX_READ_REG   = 8'h14;
	localparam logic [7:0] IDX_CAUSE      = 8'h15;
	localparam logic [7:0] IDX_PAYLOAD    = 8'h16;
	localparam logic [7:0] IDX_STOP       = 8'h18;
	localparam logic [7:0] IDX_SCRATCH    = 8'h20;
	localparam logic [7:0] IDX_IB_ADDR    = 8'h30;
	localparam logic [7:0] IDX_IB_CTL     = 8'h40;
	localparam logic [7:0] IDX_DW_ADDR1   = 8'h50;
	localparam logic [7:0] IDX_DW_ADDR2   = 8'h60;
	localparam logic [7:0] IDX_DW_CTL     = 8'h70;
	localparam logic [7:0] IDX_RW_MASK    = 8'h80;
	localparam logic [7:0] IDX_RW_VALUE   = 8'h90;
	localparam logic [7:0] IDX_RW_CTL     = 8'h9C;

	// ************************************************************
	// fields and writable-bit masks
	// ************************************************************
	localparam int CTL_EN_BIT    = 0;
	localparam int CTL_MODE_BIT  = 1;
	localparam int CTL_LOAD_BIT  = 2;
	localparam int CTL_THR_LSB   = 16;
	localparam int CAUSE_THR_LSB = 8;
	localparam int CAUSE_IX_LSB  = 16;
	localparam logic [31:0] IB_CTL_MASK   = 32'h00FF0003;
	localparam logic [31:0] DW_CTL_MASK   = 32'h00FF0007;
	localparam logic [31:0] RW_CTL_MASK   = 32'h00FF0003;
	localparam logic [31:0] READ_THR_MASK = 32'h000000FF;
	localparam logic [31:0] READ_REG_MASK = 32'h0000001F;
	localparam logic [31:0] STOP_MASK     = 32'h000000FF;
	localparam logic [31:0] CAUSE_MASK    = 32'h0003FF07;
	localparam logic [31:0] ZERO_WORD     = 32'h00000000;

	typedef enum logic [2:0] {
		CAUSE_NONE     = 3'b000,
		CAUSE_HOST     = 3'b001,
		CAUSE_CALL     = 3'b010,
		CAUSE_IBREAK   = 3'b011,
		CAUSE_DWATCH   = 3'b100,
		CAUSE_RWATCH   = 3'b101
	} cause_t;

	// ************************************************************
	// carriers from the logical cores
	// ************************************************************
	typedef struct packed {
		logic                   valid;
		logic [THREAD_IX_W-1:0] thread;
	} thread_event_t;

	typedef struct packed {
		logic                   valid;
		logic [THREAD_IX_W-1:0] thread;
		logic [31:0]            pc;
	} pc_probe_t;

	typedef struct packed {
		logic                   valid;
		logic                   is_load;
		logic [THREAD_IX_W-1:0] thread;
		logic [31:0]            addr;
	} mem_probe_t;

	typedef struct packed {
		logic                   valid;
		logic [THREAD_IX_W-1:0] thread;
		logic [31:0]            rid;
	} res_probe_t;

	typedef struct packed {
		logic        valid;
		logic [31:0] sp;
	} entry_capture_t;

	typedef struct packed {
		logic        valid;
		logic [2:0]  index;
		logic [31:0] data;
	} scratch_write_t;

endpackage

// *** src/hardware_breakpoint_debug_unit.sv ***
// debug state and breakpoint logic behind an avalon-mm register slave
`timescale 1ns/1ps
module hardware_breakpoint_debug_unit
	import dbg_unit_pkg::*;
#(
	parameter int THREADS = NUM_THREADS
) (
	input  wire logic                core_clk,
	input  wire logic                rst,
	input  wire logic                ce,
	input  wire logic [ADDR_W-1:0]   avs_address,
	input  wire logic                avs_read,
	input  wire logic                avs_write,
	input  wire logic [DATA_W-1:0]   avs_writedata,
	output logic      [DATA_W-1:0]   avs_readdata,
	output logic                     avs_waitrequest,
	input  wire logic                debug_mode,
	input  wire logic                host_debug_request,
	input  wire thread_event_t       debug_call_instruction,
	input  wire entry_capture_t      debug_entry,
	input  wire pc_probe_t           pc_probe,
	input  wire mem_probe_t          mem_probe,
	input  wire res_probe_t          res_probe,
	input  wire scratch_write_t      cfg_scratch_write,
	output logic                     debug_irq,
	output logic [NUM_THREADS-1:0]   thread_stop,
	output logic [7:0]               read_thread_select,
	output logic [4:0]               read_register_select
);

	// ************************************************************
	// elaboration checks
	// ************************************************************
	if (THREADS != NUM_THREADS) begin : g_bad_threads
		$error("THREADS must equal the eight-bit thread mask width");
	end

	// ************************************************************
	// helpers
	// ************************************************************
	// armed for this thread: enable bit and the thread's mask bit
	function automatic logic ctl_armed(input logic [31:0] ctl,
			input logic [THREAD_IX_W-1:0] thr);
		ctl_armed = ctl[CTL_EN_BIT] & ctl[CTL_THR_LSB + int'(thr)];
	endfunction

	// lowest firing unit wins
	function automatic logic [1:0] lowest_hit(input logic [NUM_UNITS-1:0] hits);
		lowest_hit = 2'h0;
		for (int i = NUM_UNITS - 1; i >= 0; i--) begin
			if (hits[i]) begin
				lowest_hit = 2'(i);
			end
		end
	endfunction

	// word inside a block of four or eight at base
	function automatic logic in_block(input logic [7:0] ix, input logic [7:0] base,
			input logic [7:0] len);
		in_block = (ix >= base) && (ix < 8'(base + len));
	endfunction

	// ************************************************************
	// state
	// ************************************************************
	logic [31:0] saved_sp_reg;
	logic [31:0] read_thr_reg;
	logic [31:0] read_regsel_reg;
	logic [31:0] cause_reg;
	logic [31:0] payload_reg;
	logic [31:0] stop_reg;
	logic [31:0] scratch_reg [NUM_SCRATCH];
	logic [31:0] ib_addr_reg [NUM_UNITS];
	logic [31:0] ib_ctl_reg  [NUM_UNITS];
	logic [31:0] dw_a1_reg   [NUM_UNITS];
	logic [31:0] dw_a2_reg   [NUM_UNITS];
	logic [31:0] dw_ctl_reg  [NUM_UNITS];
	logic [31:0] rw_mask_reg [NUM_UNITS];
	logic [31:0] rw_val_reg  [NUM_UNITS];
	logic [31:0] rw_ctl_reg  [NUM_UNITS];
	logic        ack_reg;
	logic [31:0] rdata_reg;
	logic        irq_reg;
	logic [7:0]  stop_out_reg;

	// ************************************************************
	// bus decode
	// ************************************************************
	// one wait cycle per access: ack rises the cycle after the request
	wire        bus_req   = avs_read | avs_write;
	wire        ack_next  = bus_req & ~ack_reg;
	wire [7:0]  bus_ix    = avs_address[ADDR_W-1:2];
	wire [1:0]  unit_ix   = bus_ix[1:0];
	wire [2:0]  scr_ix    = bus_ix[2:0];
	// debug-mode-only writes keep running threads from corrupting state
	wire        wr_go     = avs_write & ack_reg & debug_mode;
	wire        hit_sp    = bus_ix == IDX_SAVED_SP;
	wire        hit_thr   = bus_ix == IDX_READ_THR;
	wire        hit_rsel  = bus_ix == IDX_READ_REG;
	wire        hit_cause = bus_ix == IDX_CAUSE;
	wire        hit_pay   = bus_ix == IDX_PAYLOAD;
	wire        hit_stop  = bus_ix == IDX_STOP;
	wire        hit_scr   = in_block(bus_ix, IDX_SCRATCH, 8'(NUM_SCRATCH));
	wire        hit_iba   = in_block(bus_ix, IDX_IB_ADDR, 8'(NUM_UNITS));
	wire        hit_ibc   = in_block(bus_ix, IDX_IB_CTL, 8'(NUM_UNITS));
	wire        hit_dwa1  = in_block(bus_ix, IDX_DW_ADDR1, 8'(NUM_UNITS));
	wire        hit_dwa2  = in_block(bus_ix, IDX_DW_ADDR2, 8'(NUM_UNITS));
	wire        hit_dwc   = in_block(bus_ix, IDX_DW_CTL, 8'(NUM_UNITS));
	wire        hit_rwm   = in_block(bus_ix, IDX_RW_MASK, 8'(NUM_UNITS));
	wire        hit_rwv   = in_block(bus_ix, IDX_RW_VALUE, 8'(NUM_UNITS));
	wire        hit_rwc   = in_block(bus_ix, IDX_RW_CTL, 8'(NUM_UNITS));

	// unmapped words read as zero
	wire [31:0] rd_word =
		hit_sp    ? saved_sp_reg :
		hit_thr   ? read_thr_reg :
		hit_rsel  ? read_regsel_reg :
		hit_cause ? cause_reg :
		hit_pay   ? payload_reg :
		hit_stop  ? stop_reg :
		hit_scr   ? scratch_reg[scr_ix] :
		hit_iba   ? ib_addr_reg[unit_ix] :
		hit_ibc   ? ib_ctl_reg[unit_ix] :
		hit_dwa1  ? dw_a1_reg[unit_ix] :
		hit_dwa2  ? dw_a2_reg[unit_ix] :
		hit_dwc   ? dw_ctl_reg[unit_ix] :
		hit_rwm   ? rw_mask_reg[unit_ix] :
		hit_rwv   ? rw_val_reg[unit_ix] :
		hit_rwc   ? rw_ctl_reg[unit_ix] : ZERO_WORD;

	// ************************************************************
	// watch logic
	// ************************************************************
	logic [NUM_UNITS-1:0] ib_hit;
	logic [NUM_UNITS-1:0] dw_hit;
	logic [NUM_UNITS-1:0] rw_hit;

	for (genvar u = 0; u < NUM_UNITS; u++) begin : g_watch
		wire pc_eq   = pc_probe.pc == ib_addr_reg[u];
		wire pc_cmp  = ib_ctl_reg[u][CTL_MODE_BIT] ? ~pc_eq : pc_eq;
		assign ib_hit[u] = pc_probe.valid & ctl_armed(ib_ctl_reg[u], pc_probe.thread)
			& pc_cmp;

		wire dw_a    = mem_probe.addr >= dw_a1_reg[u];
		wire dw_b    = mem_probe.addr <= dw_a2_reg[u];
		wire dw_cond = dw_ctl_reg[u][CTL_MODE_BIT] ? (dw_a | dw_b) : (dw_a & dw_b);
		wire dw_kind = ~mem_probe.is_load | dw_ctl_reg[u][CTL_LOAD_BIT];
		assign dw_hit[u] = mem_probe.valid & ctl_armed(dw_ctl_reg[u], mem_probe.thread)
			& dw_kind & dw_cond;

		wire rw_eq   = (res_probe.rid & rw_mask_reg[u]) == (rw_val_reg[u] & rw_mask_reg[u]);
		wire rw_cond = rw_ctl_reg[u][CTL_MODE_BIT] ? ~rw_eq : rw_eq;
		assign rw_hit[u] = res_probe.valid & ctl_armed(rw_ctl_reg[u], res_probe.thread)
			& rw_cond;
	end

	// events are ignored while the debugger already runs
	wire armed_run = ~debug_mode;
	wire ev_host   = armed_run & host_debug_request;
	wire ev_call   = armed_run & debug_call_instruction.valid;
	wire ev_ib     = armed_run & (|ib_hit);
	wire ev_dw     = armed_run & (|dw_hit);
	wire ev_rw     = armed_run & (|rw_hit);
	wire ev_any    = ev_host | ev_call | ev_ib | ev_dw | ev_rw;

	// priority: host, call, instruction, data, resource
	wire [2:0] cause_code =
		ev_host ? CAUSE_HOST :
		ev_call ? CAUSE_CALL :
		ev_ib   ? CAUSE_IBREAK :
		ev_dw   ? CAUSE_DWATCH : CAUSE_RWATCH;
	wire [1:0] cause_ix =
		(ev_host | ev_call) ? 2'h0 :
		ev_ib   ? lowest_hit(ib_hit) :
		ev_dw   ? lowest_hit(dw_hit) : lowest_hit(rw_hit);
	wire [THREAD_IX_W-1:0] cause_thr =
		ev_host ? '0 :
		ev_call ? debug_call_instruction.thread :
		ev_ib   ? pc_probe.thread :
		ev_dw   ? mem_probe.thread : res_probe.thread;
	wire [31:0] cause_word = {14'h0000, cause_ix, 5'h00, cause_thr, 5'h00, cause_code};
	wire        pay_load   = ev_dw | ev_rw;
	wire [31:0] pay_word   = ev_dw ? mem_probe.addr : res_probe.rid;

	// ************************************************************
	// bus handshake and outputs
	// ************************************************************
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ack_reg   <= 1'b0;
			rdata_reg <= ZERO_WORD;
		end else if (ce) begin
			ack_reg <= ack_next;
			if (ack_next) begin
				rdata_reg <= rd_word;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			irq_reg      <= 1'b0;
			stop_out_reg <= 8'h00;
		end else if (ce) begin
			irq_reg      <= ev_any;
			stop_out_reg <= debug_mode ? 8'h00 : stop_reg[7:0];
		end
	end

	// ************************************************************
	// debug state registers; hardware capture beats a bus write
	// ************************************************************
	always_ff @(posedge core_clk) begin
		if (rst) begin
			saved_sp_reg <= ZERO_WORD;
		end else if (ce) begin
			if (debug_entry.valid) begin
				saved_sp_reg <= debug_entry.sp;
			end else if (wr_go && hit_sp) begin
				saved_sp_reg <= avs_writedata;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			read_thr_reg <= ZERO_WORD;
		end else if (ce && wr_go && hit_thr) begin
			read_thr_reg <= avs_writedata & READ_THR_MASK;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			read_regsel_reg <= ZERO_WORD;
		end else if (ce && wr_go && hit_rsel) begin
			read_regsel_reg <= avs_writedata & READ_REG_MASK;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			cause_reg <= ZERO_WORD;
		end else if (ce) begin
			if (ev_any) begin
				cause_reg <= cause_word;
			end else if (wr_go && hit_cause) begin
				cause_reg <= avs_writedata & CAUSE_MASK;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			payload_reg <= ZERO_WORD;
		end else if (ce) begin
			if (pay_load) begin
				payload_reg <= pay_word;
			end else if (wr_go && hit_pay) begin
				payload_reg <= avs_writedata;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			stop_reg <= ZERO_WORD;
		end else if (ce && wr_go && hit_stop) begin
			stop_reg <= avs_writedata & STOP_MASK;
		end
	end

	// ************************************************************
	// scratch words, shared with the configuration path
	// ************************************************************
	always_ff @(posedge core_clk) begin
		if (rst) begin
			for (int i = 0; i < NUM_SCRATCH; i++) begin
				scratch_reg[i] <= ZERO_WORD;
			end
		end else if (ce) begin
			if (wr_go && hit_scr) begin
				scratch_reg[scr_ix] <= avs_writedata;
			end else if (cfg_scratch_write.valid) begin
				scratch_reg[cfg_scratch_write.index] <= cfg_scratch_write.data;
			end
		end
	end

	// ************************************************************
	// watch unit registers
	// ************************************************************
	always_ff @(posedge core_clk) begin
		if (rst) begin
			for (int i = 0; i < NUM_UNITS; i++) begin
				ib_addr_reg[i] <= ZERO_WORD;
			end
		end else if (ce && wr_go && hit_iba) begin
			ib_addr_reg[unit_ix] <= avs_writedata;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			for (int i = 0; i < NUM_UNITS; i++) begin
				ib_ctl_reg[i] <= ZERO_WORD;
			end
		end else if (ce && wr_go && hit_ibc) begin
			ib_ctl_reg[unit_ix] <= avs_writedata & IB_CTL_MASK;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			for (int i = 0; i < NUM_UNITS; i++) begin
				dw_a1_reg[i] <= ZERO_WORD;
			end
		end else if (ce && wr_go && hit_dwa1) begin
			dw_a1_reg[unit_ix] <= avs_writedata;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			for (int i = 0; i < NUM_UNITS; i++) begin
				dw_a2_reg[i] <= ZERO_WORD;
			end
		end else if (ce && wr_go && hit_dwa2) begin
			dw_a2_reg[unit_ix] <= avs_writedata;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			for (int i = 0; i < NUM_UNITS; i++) begin
				dw_ctl_reg[i] <= ZERO_WORD;
			end
		end else if (ce && wr_go && hit_dwc) begin
			dw_ctl_reg[unit_ix] <= avs_writedata & DW_CTL_MASK;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			for (int i = 0; i < NUM_UNITS; i++) begin
				rw_mask_reg[i] <= ZERO_WORD;
			end
		end else if (ce && wr_go && hit_rwm) begin
			rw_mask_reg[unit_ix] <= avs_writedata;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			for (int i = 0; i < NUM_UNITS; i++) begin
				rw_val_reg[i] <= ZERO_WORD;
			end
		end else if (ce && wr_go && hit_rwv) begin
			rw_val_reg[unit_ix] <= avs_writedata;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			for (int i = 0; i < NUM_UNITS; i++) begin
				rw_ctl_reg[i] <= ZERO_WORD;
			end
		end else if (ce && wr_go && hit_rwc) begin
			rw_ctl_reg[unit_ix] <= avs_writedata & RW_CTL_MASK;
		end
	end

	assign avs_readdata         = rdata_reg;
	assign avs_waitrequest      = ~ack_reg;
	assign debug_irq            = irq_reg;
	assign thread_stop          = stop_out_reg;
	assign read_thread_select   = read_thr_reg[7:0];
	assign read_register_select = read_regsel_reg[4:0];

endmodule // hardware_breakpoint_debug_unit

// *** verification/hardware_breakpoint_debug_unit_checker.sv ***
// port assertions of the debug unit
`timescale 1ns/1ps
module hardware_breakpoint_debug_unit_checker
	import dbg_unit_pkg::*;
(
	input wire logic          core_clk,
	input wire logic          rst,
	input wire logic          ce,
	input wire logic [9:0]    avs_address,
	input wire logic          avs_read,
	input wire logic          avs_write,
	input wire logic [31:0]   avs_writedata,
	input wire logic          avs_waitrequest,
	input wire logic          debug_mode,
	input wire logic          host_debug_request,
	input wire thread_event_t debug_call_instruction,
	input wire logic          debug_irq,
	input wire logic [7:0]    thread_stop,
	input wire logic [7:0]    read_thread_select
);
	// ************************************************************
	// bus handshake
	// ************************************************************
	AST_ONE_WAIT: assert property (@(posedge core_clk) disable iff (rst)
		ce && (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("request not answered after one wait state");
	AST_ACK_PULSE: assert property (@(posedge core_clk) disable iff (rst)
		ce && !avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	AST_IDLE_WAIT: assert property (@(posedge core_clk) disable iff (rst)
		ce && !avs_read && !avs_write |=> avs_waitrequest)
		else $error("ack without request");
	// operand reaches its port one edge after the write lands; checked at the second
	AST_SEL_WRITE: assert property (@(posedge core_clk) disable iff (rst)
		ce && debug_mode && avs_write && !avs_waitrequest && avs_address[9:2] == IDX_READ_THR
		|-> ##2 read_thread_select == $past(avs_writedata[7:0], 2))
		else $error("thread select not taken from write");
	// ************************************************************
	// events
	// ************************************************************
	AST_HOST_IRQ: assert property (@(posedge core_clk) disable iff (rst)
		ce && !debug_mode && host_debug_request |=> debug_irq)
		else $error("host request gave no irq");
	AST_CALL_IRQ: assert property (@(posedge core_clk) disable iff (rst)
		ce && !debug_mode && debug_call_instruction.valid |=> debug_irq)
		else $error("debug call gave no irq");
	AST_MODE_QUIET: assert property (@(posedge core_clk) disable iff (rst)
		ce && debug_mode |=> !debug_irq)
		else $error("irq while in debug mode");
	AST_IRQ_CAUSE: assert property (@(posedge core_clk) disable iff (rst)
		debug_irq |-> $past(!debug_mode))
		else $error("irq without a run-mode cycle before it");
	AST_STOP_HELD: assert property (@(posedge core_clk) disable iff (rst)
		ce && debug_mode |=> thread_stop == 8'h00)
		else $error("threads stopped inside debug mode");
endmodule // hardware_breakpoint_debug_unit_checker

bind hardware_breakpoint_debug_unit hardware_breakpoint_debug_unit_checker i_chk (
	.core_clk, .rst, .ce, .avs_address, .avs_read, .avs_write, .avs_writedata,
	.avs_waitrequest, .debug_mode, .host_debug_request, .debug_call_instruction,
	.debug_irq, .thread_stop, .read_thread_select
);

// *** verification/core_model.sv ***
// behavioural model of the logical cores feeding the probes
`timescale 1ns/1ps
module core_model
	import dbg_unit_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        go,
	input  wire logic [2:0]  kind,
	input  wire logic        is_load,
	input  wire logic [2:0]  thread,
	input  wire logic [31:0] value,
	output logic             host_req,
	output thread_event_t    call_ev,
	output entry_capture_t   entry,
	output pc_probe_t        pc,
	output mem_probe_t       mem,
	output res_probe_t       res,
	output scratch_write_t   scr
);
	// idle payloads invert so a stale value never looks like a live one
	logic [31:0] v;
	assign v = go ? value : ~value;
	always @(posedge core_clk) begin
		host_req <= go && kind == 3'h1;
		call_ev  <= '{go && kind == 3'h2, thread};
		pc       <= '{go && kind == 3'h3, thread, v};
		mem      <= '{go && kind == 3'h4, is_load, thread, v};
		res      <= '{go && kind == 3'h5, thread, v};
		entry    <= '{go && kind == 3'h6, v};
		scr      <= '{go && kind == 3'h7, thread, v};
	end
endmodule // core_model

// *** verification/hardware_breakpoint_debug_unit_tb.sv ***
// self-checking testbench of the debug unit
`timescale 1ns/1ps
module hardware_breakpoint_debug_unit_tb;
	import dbg_unit_pkg::*;
	typedef struct packed {
		logic [7:0]  idx;
		logic [31:0] wd;
		logic [31:0] ex;
	} row_t;
	logic           core_clk, rst = 1'b1, ce = 1'b1, debug_mode = 1'b1, go = 1'b0;
	logic           avs_read = 1'b0, avs_write = 1'b0, is_load = 1'b0;
	logic [9:0]     avs_address = 10'h000;
	logic [31:0]    avs_writedata = 32'h0, value = 32'h0, avs_readdata, rdat;
	logic [2:0]     kind = 3'h0, thread = 3'h0;
	logic           avs_waitrequest, debug_irq, host_req;
	logic [7:0]     thread_stop, read_thread_select;
	logic [4:0]     read_register_select;
	thread_event_t  call_ev;
	entry_capture_t entry;
	pc_probe_t      pc;
	mem_probe_t     mem;
	res_probe_t     res;
	scratch_write_t scr;
	int             miscompares = 0, num_checks = 0;
	// ************************************************************
	// register rows: index, write data, read-back
	// ************************************************************
	row_t rows[16] = '{
		'{8'h12, 32'hFFFFFFFF, 32'hFFFFFFFF}, '{8'h13, 32'hFFFFFFFF, 32'h000000FF},
		'{8'h14, 32'hFFFFFFFF, 32'h0000001F}, '{8'h15, 32'hFFFFFFFF, 32'h0003FF07},
		'{8'h16, 32'hA5A5A5A5, 32'hA5A5A5A5}, '{8'h18, 32'hFFFFFFFF, 32'h000000FF},
		'{8'h27, 32'h12345678, 32'h12345678}, '{8'h33, 32'hDEADBEEF, 32'hDEADBEEF},
		'{8'h43, 32'hFFFFFFFE, 32'h00FF0002}, '{8'h53, 32'h11111111, 32'h11111111},
		'{8'h63, 32'h22222222, 32'h22222222}, '{8'h73, 32'hFFFFFFFE, 32'h00FF0006},
		'{8'h83, 32'h33333333, 32'h33333333}, '{8'h93, 32'h44444444, 32'h44444444},
		'{8'h9F, 32'hFFFFFFFE, 32'h00FF0002}, '{8'h19, 32'hFFFFFFFF, 32'h00000000}};
	// breakpoint setup; the last column is unused
	row_t cfg[16] = '{
		'{8'h30, 32'h100, 0}, '{8'h40, 32'h00040001, 0}, '{8'h32, 32'h300, 0},
		'{8'h42, 32'h00200003, 0}, '{8'h50, 32'h1000, 0}, '{8'h60, 32'h1FFF, 0},
		'{8'h70, 32'h00FF0001, 0}, '{8'h51, 32'h8000, 0}, '{8'h61, 32'h0, 0},
		'{8'h71, 32'h00FF0007, 0}, '{8'h80, 32'hFF, 0}, '{8'h90, 32'h42, 0},
		'{8'h9C, 32'h00FF0001, 0}, '{8'h81, 32'hFFFFFFFF, 0}, '{8'h91, 32'h0, 0},
		'{8'h9D, 32'h00FF0003, 0}};
	logic [7:0] rst_idx[4] = '{IDX_CAUSE, IDX_IB_CTL, IDX_DW_CTL, IDX_RW_CTL};

	hardware_breakpoint_debug_unit i_dut (.core_clk(core_clk), .rst(rst), .ce(ce),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .debug_mode(debug_mode),
		.host_debug_request(host_req), .debug_call_instruction(call_ev), .debug_entry(entry),
		.pc_probe(pc), .mem_probe(mem), .res_probe(res), .cfg_scratch_write(scr),
		.debug_irq(debug_irq), .thread_stop(thread_stop),
		.read_thread_select(read_thread_select), .read_register_select(read_register_select));
	core_model i_core (.core_clk(core_clk), .go(go), .kind(kind), .is_load(is_load),
		.thread(thread), .value(value), .host_req(host_req), .call_ev(call_ev),
		.entry(entry), .pc(pc), .mem(mem), .res(res), .scr(scr));

	// ************************************************************
	// tasks
	// ************************************************************
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// one idle edge first so the previous release never collides with a new request
	task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge core_clk);
		avs_address <= {idx, 2'b00};
		avs_writedata <= wd;
		avs_write <= w;
		avs_read <= !w;
		do begin
			@(posedge core_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		rdat = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 50) miscompares++;
	endtask
	task automatic ev(input logic [2:0] k, input logic [2:0] t, input logic l,
		input logic [31:0] v, input logic irq, input logic [31:0] cs);
		@(posedge core_clk);
		go <= 1'b1;
		kind <= k;
		thread <= t;
		is_load <= l;
		value <= v;
		@(posedge core_clk);
		go <= 1'b0;
		repeat (2) @(posedge core_clk);
		chk("debug_irq", 32'(debug_irq), 32'(irq));
		if (irq) begin
			bus(1'b0, IDX_CAUSE, 32'h0);
			chk("cause", rdat, cs);
			if (k > 3'h3) begin
				bus(1'b0, IDX_PAYLOAD, 32'h0);
				chk("payload", rdat, v);
			end
		end
	endtask
	task automatic complete_run;
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ************************************************************
	// clock, watchdog, main sequence
	// ************************************************************
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		miscompares++;
		complete_run;
	end
	initial begin
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			bus(1'b0, rst_idx[i], 32'h0);
			chk("reset", rdat, 32'h0);
		end
		for (int i = 0; i < 16; i++) begin
			bus(1'b1, rows[i].idx, rows[i].wd);
			bus(1'b0, rows[i].idx, 32'h0);
			chk("register", rdat, rows[i].ex);
		end
		chk("thread_sel", 32'(read_thread_select), 32'h000000FF);
		chk("reg_sel", 32'(read_register_select), 32'h0000001F);
		chk("stop_in_debug", 32'(thread_stop), 32'h0);
		for (int i = 0; i < 16; i++)
			bus(1'b1, cfg[i].idx, cfg[i].wd);
		debug_mode <= 1'b0;
		repeat (2) @(posedge core_clk);
		chk("stop_run", 32'(thread_stop), 32'h000000FF);
		ev(3'h6, 3'h0, 1'b0, 32'hCAFE0001, 1'b0, 32'h0);
		bus(1'b0, IDX_SAVED_SP, 32'h0);
		chk("saved_sp", rdat, 32'hCAFE0001);
		ev(3'h1, 3'h4, 1'b0, 32'h0, 1'b1, 32'h00000001);
		ev(3'h2, 3'h6, 1'b0, 32'h0, 1'b1, 32'h00000602);
		ev(3'h3, 3'h2, 1'b0, 32'h100, 1'b1, 32'h00000203);
		ev(3'h3, 3'h5, 1'b0, 32'h100, 1'b1, 32'h00020503);
		ev(3'h3, 3'h5, 1'b0, 32'h300, 1'b0, 32'h0);
		ev(3'h3, 3'h4, 1'b0, 32'h100, 1'b0, 32'h0);
		ev(3'h4, 3'h1, 1'b0, 32'h1800, 1'b1, 32'h00000104);
		ev(3'h4, 3'h1, 1'b1, 32'h1800, 1'b0, 32'h0);
		ev(3'h4, 3'h1, 1'b1, 32'h9000, 1'b1, 32'h00010104);
		ev(3'h4, 3'h1, 1'b0, 32'h2000, 1'b0, 32'h0);
		ev(3'h5, 3'h3, 1'b0, 32'h142, 1'b1, 32'h00000305);
		ev(3'h5, 3'h3, 1'b0, 32'h43, 1'b1, 32'h00010305);
		ce <= 1'b0;
		ev(3'h1, 3'h0, 1'b0, 32'h0, 1'b0, 32'h0);
		ce <= 1'b1;
		bus(1'b0, IDX_CAUSE, 32'h0);
		chk("ce_freeze", rdat, 32'h00010305);
		ev(3'h7, 3'h5, 1'b0, 32'h5A5A, 1'b0, 32'h0);
		bus(1'b1, 8'h25, 32'h1);
		bus(1'b0, 8'h25, 32'h0);
		chk("scratch", rdat, 32'h5A5A);
		debug_mode <= 1'b1;
		ev(3'h1, 3'h0, 1'b0, 32'h0, 1'b0, 32'h0);
		ev(3'h3, 3'h2, 1'b0, 32'h100, 1'b0, 32'h0);
		chk("stop_back", 32'(thread_stop), 32'h0);
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			bus(1'b0, rst_idx[i], 32'h0);
			chk("mid_reset", rdat, 32'h0);
		end
		chk("sel_reset", 32'(read_thread_select), 32'h0);
		complete_run;
	end
endmodule // hardware_breakpoint_debug_unit_tb
